// file: rtl/lahp_pkg.sv
// Package of constants for the link adaptor host port
// Notes on behaviour
// - Arriving data packet sets receive-valid flag
// - Only data read or reset clears receive-valid
// - Data read clears flag, sends acknowledge
// - Enable bits written directly, read back
// - Receive irq equals enable AND receive-valid
// - Receive irq drops on data read, reset
// - Written byte goes out as data packet
// - Transmit data read undefined, no side effect
// - Reset sets empty; only write clears
// - Data write clears empty, starts transmit
// - Empty stays low until acknowledge arrives
// - Transmit irq equals enable AND empty
// - Transmit irq drops on write, reset
// - Two selects plus direction decode registers
// - Latch select at fall, data at rise
// - Input data holds last data packet
package lahp_pkg;
    // ****************************************
    // Register select codes
    // ****************************************
    localparam logic [1:0] LAHP_SEL_DATA    = 2'h0;
    localparam logic [1:0] LAHP_SEL_TXDATA  = 2'h1;
    localparam logic [1:0] LAHP_SEL_RXSTAT  = 2'h2;
    localparam logic [1:0] LAHP_SEL_TXSTAT  = 2'h3;
    // ****************************************
    // Status field positions and reset values
    // ****************************************
    localparam int         LAHP_FLAG_BIT    = 0;
    localparam int         LAHP_IEN_BIT     = 1;
    localparam logic [5:0] LAHP_HIGH_RESET  = 6'h00;
    localparam logic [7:0] LAHP_DATA_RESET  = 8'h00;
    // Pin synchroniser depth
    localparam int         LAHP_SYNC_STAGES = 3;
    typedef logic [7:0] lahp_byte_t;
endpackage : lahp_pkg

// file: rtl/lahp_sync.sv
// Three-stage pin synchroniser, change accepted when last two agree
`timescale 1ns/1ps
`default_nettype none
module lahp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Pin and result
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // Hold last agreed value while stages disagree
    logic [W-1:0] level_q;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            level_q <= '0;
        else
            level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
    assign level_out = level_q;
endmodule : lahp_sync
`default_nettype wire

// file: rtl/lahp_port.sv
// Host parallel port of the link adaptor
`timescale 1ns/1ps
`default_nettype none
module lahp_port (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Host bus pins
    input  wire logic              chip_select_n,
    input  wire logic              read_write_dir,
    input  wire logic [1:0]        register_select_lines,
    input  wire lahp_pkg::lahp_byte_t host_data_in,
    output lahp_pkg::lahp_byte_t   host_data_out,
    output logic                   host_data_oe,
    // Interrupt pins
    output logic                   receive_irq_out,
    output logic                   transmit_irq_out,
    // Link engine side
    input  wire logic              rx_data_valid,
    input  wire lahp_pkg::lahp_byte_t rx_data,
    input  wire logic              rx_ack_seen,
    output logic                   tx_data_start,
    output lahp_pkg::lahp_byte_t   tx_data,
    output logic                   tx_ack_start
);
    import lahp_pkg::*;
    // ****************************************
    // Pin synchronisation
    // ****************************************
    // Select, direction, register select and data share one filter so they stay aligned
    logic [11:0] pins_s;
    lahp_sync #(.W(12)) u_sync (
        .clock     (clock),
        .rst       (rst),
        .pin_in    ({~chip_select_n, read_write_dir, register_select_lines, host_data_in}),
        .level_out (pins_s)
    );
    logic       cs_s;
    logic       cs_q;
    logic       cs_fall;
    logic       cs_rise;
    assign cs_s    = pins_s[11];
    assign cs_fall = cs_s & ~cs_q;
    assign cs_rise = ~cs_s & cs_q;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cs_q <= 1'b0;
        else
            cs_q <= cs_s;
    end
    // ****************************************
    // Access latch and decode
    // ****************************************
    logic       rd_q;
    logic [1:0] sel_q;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rd_q  <= 1'b1;
            sel_q <= LAHP_SEL_DATA;
        end
        else if (cs_fall)
        begin
            rd_q  <= pins_s[10];
            sel_q <= pins_s[9:8];
        end
    end
    logic data_rd_end;
    logic tx_wr_end;
    logic rx_st_wr;
    logic tx_st_wr;
    // Actions fire at deselect so bus data is stable when used
    assign data_rd_end = cs_rise & rd_q & (sel_q == LAHP_SEL_DATA);
    assign tx_wr_end   = cs_rise & ~rd_q & (sel_q == LAHP_SEL_TXDATA);
    assign rx_st_wr    = cs_rise & ~rd_q & (sel_q == LAHP_SEL_RXSTAT);
    assign tx_st_wr    = cs_rise & ~rd_q & (sel_q == LAHP_SEL_TXSTAT);
    // ****************************************
    // Receive side
    // ****************************************
    logic       rx_valid_q;
    logic       rx_ien_q;
    logic [5:0] rx_high_q;
    lahp_byte_t rx_buf_q;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rx_valid_q <= 1'b0;
        else if (rx_data_valid)
            rx_valid_q <= 1'b1;
        else if (data_rd_end)
            rx_valid_q <= 1'b0;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rx_buf_q <= LAHP_DATA_RESET;
        else if (rx_data_valid)
            rx_buf_q <= rx_data;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rx_ien_q  <= 1'b0;
            rx_high_q <= LAHP_HIGH_RESET;
        end
        else if (rx_st_wr)
        begin
            rx_ien_q  <= pins_s[LAHP_IEN_BIT];
            rx_high_q <= pins_s[7:2];
        end
    end
    // ****************************************
    // Transmit side
    // ****************************************
    logic       tx_empty_q;
    logic       tx_ien_q;
    logic [5:0] tx_high_q;
    lahp_byte_t tx_data_q;
    logic       tx_start_q;
    logic       ack_start_q;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tx_empty_q <= 1'b1;
        else if (tx_wr_end)
            tx_empty_q <= 1'b0;
        else if (rx_ack_seen & ~tx_start_q)
            tx_empty_q <= 1'b1;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tx_data_q   <= LAHP_DATA_RESET;
            tx_start_q  <= 1'b0;
            ack_start_q <= 1'b0;
        end
        else
        begin
            if (tx_wr_end)
                tx_data_q <= pins_s[7:0];
            tx_start_q  <= tx_wr_end;
            ack_start_q <= data_rd_end;
        end
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tx_ien_q  <= 1'b0;
            tx_high_q <= LAHP_HIGH_RESET;
        end
        else if (tx_st_wr)
        begin
            tx_ien_q  <= pins_s[LAHP_IEN_BIT];
            tx_high_q <= pins_s[7:2];
        end
    end
    assign tx_data_start = tx_start_q;
    assign tx_data       = tx_data_q;
    assign tx_ack_start  = ack_start_q;
    // ****************************************
    // Interrupts and read data
    // ****************************************
    assign receive_irq_out  = rx_ien_q & rx_valid_q;
    assign transmit_irq_out = tx_ien_q & tx_empty_q;
    lahp_byte_t rd_mux;
    always_comb
    begin
        case (sel_q)
            LAHP_SEL_DATA:   rd_mux = rx_buf_q;
            LAHP_SEL_RXSTAT: rd_mux = {rx_high_q, rx_ien_q, rx_valid_q};
            LAHP_SEL_TXSTAT: rd_mux = {tx_high_q, tx_ien_q, tx_empty_q};
            default:         rd_mux = LAHP_DATA_RESET;
        endcase
    end
    // Registered so the pins never glitch
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            host_data_out <= LAHP_DATA_RESET;
            host_data_oe  <= 1'b0;
        end
        else
        begin
            host_data_out <= rd_mux;
            host_data_oe  <= cs_q & cs_s & rd_q;
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    property p_rx_set;
        @(posedge clock) disable iff (rst) rx_data_valid |=> rx_valid_q;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("valid not set");
    property p_rx_hold;
        @(posedge clock) disable iff (rst)
            rx_valid_q & ~data_rd_end |=> rx_valid_q;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("valid lost");
    property p_ack;
        @(posedge clock) disable iff (rst)
            data_rd_end & ~rx_data_valid |=> ~rx_valid_q & tx_ack_start;
    endproperty
    a_ack: assert property (p_ack) else $error("read effects missing");
    property p_ien;
        @(posedge clock) disable iff (rst)
            rx_st_wr |=> rx_ien_q == $past(pins_s[1]);
    endproperty
    a_ien: assert property (p_ien) else $error("enable not written");
    property p_rxirq;
        @(posedge clock) disable iff (rst)
            rx_st_wr & rx_valid_q |=> receive_irq_out == $past(pins_s[LAHP_IEN_BIT]);
    endproperty
    a_rxirq: assert property (p_rxirq) else $error("rx irq wrong");
    property p_rxirq_drop;
        @(posedge clock) disable iff (rst)
            data_rd_end & ~rx_data_valid |=> ~receive_irq_out;
    endproperty
    a_rxirq_drop: assert property (p_rxirq_drop) else $error("rx irq stuck");
    property p_tx;
        @(posedge clock) disable iff (rst)
            tx_wr_end |=> tx_data_start & ~tx_empty_q & ~transmit_irq_out;
    endproperty
    a_tx: assert property (p_tx) else $error("write effects missing");
    property p_empty_hold;
        @(posedge clock) disable iff (rst)
            ~tx_empty_q & ~rx_ack_seen |=> ~tx_empty_q;
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("empty early");
    property p_txirq;
        @(posedge clock) disable iff (rst)
            tx_st_wr & tx_empty_q |=> transmit_irq_out == $past(pins_s[LAHP_IEN_BIT]);
    endproperty
    a_txirq: assert property (p_txirq) else $error("tx irq wrong");
endmodule : lahp_port
`default_nettype wire

// file: verif/lahp_host_model.sv
// Host processor model for the chip-select register bus
`timescale 1ns/1ps
`default_nettype none
module lahp_host_model
    import lahp_pkg::*;
(
    // Clock
    input  wire logic        clock,
    // Bus pins
    output logic             chip_select_n,
    output logic             read_write_dir,
    output logic [1:0]       register_select_lines,
    output lahp_byte_t       host_data_in,
    input  wire lahp_byte_t  host_data_out,
    // Captured read
    output logic             rd_seen,
    output lahp_byte_t       rd_byte
);
    initial
    begin
        chip_select_n = 1'b1;
        read_write_dir = 1'b1;
        register_select_lines = 2'h0;
        host_data_in = 8'h5a;
        rd_seen = 1'b0;
        rd_byte = 8'h00;
    end
    // ****
    // One access; pins are async, so hold long past the sync delay
    // ****
    task automatic acc(input logic rd, input logic [1:0] sel, input lahp_byte_t d);
        @(posedge clock);
        read_write_dir <= rd;
        register_select_lines <= sel;
        host_data_in <= rd ? ~host_data_in : d;
        @(posedge clock);
        chip_select_n <= 1'b0;
        repeat (10) @(posedge clock);
        rd_seen <= rd;
        rd_byte <= host_data_out;
        chip_select_n <= 1'b1;
        @(posedge clock);
        rd_seen <= 1'b0;
        repeat (9) @(posedge clock);
        host_data_in <= ~host_data_in;
    endtask : acc
endmodule : lahp_host_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
    import lahp_pkg::*;
    logic       clock, rst, chip_select_n, read_write_dir, host_data_oe, rd_seen;
    logic       receive_irq_out, transmit_irq_out, rx_data_valid, rx_ack_seen;
    logic       tx_data_start, tx_ack_start;
    logic [1:0] register_select_lines;
    lahp_byte_t host_data_in, host_data_out, rx_data, tx_data, rd_byte, b;
    logic [9:0] exp_q[$];
    logic [9:0] e, g;
    int         mismatches, compares;
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    lahp_port i_dut (.clock(clock), .rst(rst), .chip_select_n(chip_select_n),
        .read_write_dir(read_write_dir), .register_select_lines(register_select_lines),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .receive_irq_out(receive_irq_out),
        .transmit_irq_out(transmit_irq_out), .rx_data_valid(rx_data_valid),
        .rx_data(rx_data), .rx_ack_seen(rx_ack_seen), .tx_data_start(tx_data_start),
        .tx_data(tx_data), .tx_ack_start(tx_ack_start));
    lahp_host_model i_host (.clock(clock), .chip_select_n(chip_select_n),
        .read_write_dir(read_write_dir), .register_select_lines(register_select_lines),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .rd_seen(rd_seen), .rd_byte(rd_byte));
    // ****
    // Tasks
    // ****
    task automatic finish_test;
        if (exp_q.size() != 0)
            mismatches++;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic rd(input logic [1:0] sel, input lahp_byte_t x);
        exp_q.push_back({2'h1, x});
        i_host.acc(1'b1, sel, 8'h00);
    endtask : rd
    // Link pulse; data line changes after the pulse so stale bytes show
    task automatic link(input logic ack, input lahp_byte_t d);
        @(posedge clock);
        rx_data_valid <= ~ack;
        rx_ack_seen <= ack;
        rx_data <= d;
        @(posedge clock);
        rx_data_valid <= 1'b0;
        rx_ack_seen <= 1'b0;
        rx_data <= ~d;
        repeat (2) @(posedge clock);
    endtask : link
    // Oldest note against each result: 1 read, 2 data sent, 3 acknowledge
    always @(posedge clock)
    begin
        if (rd_seen | tx_data_start | tx_ack_start)
        begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h3ff;
            g = rd_seen ? {2'h1, rd_byte} : tx_data_start ? {2'h2, tx_data} : {2'h3, 8'h00};
            `CHK("result", e, g)
        end
        if (rd_seen)
            `CHK("read oe", 1'b1, host_data_oe)
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        finish_test();
    end
    initial
    begin
        rst = 1'b1;
        rx_data_valid = 1'b0;
        rx_ack_seen = 1'b0;
        rx_data = 8'h00;
        mismatches = 0;
        compares = 0;
        void'($urandom(1));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(LAHP_SEL_RXSTAT, 8'h00);
        rd(LAHP_SEL_TXSTAT, 8'h01);
        `CHK("irqs", 2'h0, {receive_irq_out, transmit_irq_out})
        `CHK("oe idle", 1'b0, host_data_oe)
        i_host.acc(1'b0, LAHP_SEL_TXSTAT, 8'h02);
        `CHK("tx irq on", 1'b1, transmit_irq_out)
        for (int i = 0; i < 3; i++)
        begin
            b = 8'($urandom);
            exp_q.push_back({2'h2, b});
            i_host.acc(1'b0, LAHP_SEL_TXDATA, b);
            `CHK("tx irq off", 1'b0, transmit_irq_out)
            rd(LAHP_SEL_TXDATA, 8'h00);
            rd(LAHP_SEL_TXSTAT, 8'h02);
            link(1'b1, b);
            `CHK("tx irq back", 1'b1, transmit_irq_out)
            i_host.acc(1'b0, LAHP_SEL_RXSTAT, 8'h02);
            link(1'b0, ~b);
            `CHK("rx irq", 1'b1, receive_irq_out)
            i_host.acc(1'b0, LAHP_SEL_RXSTAT, 8'h00);
            `CHK("rx irq masked", 1'b0, receive_irq_out)
            rd(LAHP_SEL_RXSTAT, 8'h01);
            i_host.acc(1'b0, LAHP_SEL_DATA, b);
            i_host.acc(1'b0, LAHP_SEL_RXSTAT, 8'h02);
            `CHK("rx irq again", 1'b1, receive_irq_out)
            // Acknowledge follows the read result, so both notes go in first
            exp_q.push_back({2'h1, ~b});
            exp_q.push_back({2'h3, 8'h00});
            i_host.acc(1'b1, LAHP_SEL_DATA, 8'h00);
            `CHK("rx irq read", 1'b0, receive_irq_out)
            rd(LAHP_SEL_RXSTAT, 8'h02);
        end
        repeat (20) @(posedge clock);
        finish_test();
    end
endmodule : tb
`default_nettype wire
